//--- src/rpoc_top.sv
// Behaviour
// - port runs at most one function: trigger, inhibit with fault, or digital I/O; spare mode runs none.
// - trigger function: pin one is trigger input, fault pin left undriven.
// - inhibit function: pin one is remote inhibit, second pin drives fault level.
// - digital I/O function: software reads input pin and sets output pin.
// - three trigger sources; only the selected one yields trigger events.
// - key source: one trigger pulse per shifted trigger key press.
// - external source: pin pulse held high at least 5 ms counts as trigger.
// - bus source: a bus trigger command produces a trigger event.
// - latching inhibit: falling edge turns output off until software clears it.
// - live inhibit: output follows inhibit level, on high, off low.
// - inhibit off: inhibit level and edges do not touch output.
// - enabled timer counts programmed seconds to zero, then output turns off.
// - fault pin is selected status bit inverted.
// - fault source off holds fault pin high.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
module rpoc_top #(
    parameter int TRIG_MIN_CYCLES = rpoc_pkg::TRIG_MIN_CYCLES,
    parameter int SECOND_CYCLES = rpoc_pkg::SECOND_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic inhibit_input_pin,
    output logic fault_output_pin,
    output logic fault_output_pin_oe,
    input wire logic trigger_key,
    input wire logic [3:0] status_bits,
    output logic trigger_pulse,
    output logic output_on,
    output logic irq
);
    logic [10:0] ctrl;
    logic [rpoc_pkg::TIMER_W-1:0] timer_load;
    logic [rpoc_pkg::TIMER_W-1:0] timer_left;
    logic [31:0] sec_count;
    logic timer_run;
    logic timer_expired;
    logic latched_off;
    logic dio_out;
    logic [rpoc_pkg::IRQ_W-1:0] irq_status;
    logic [rpoc_pkg::IRQ_W-1:0] irq_mask;
    logic [rpoc_pkg::IRQ_W-1:0] irq_event;
    logic out_prev;
    logic out_req_set;
    logic bus_trig;
    logic clr_latch;
    logic next_trigger;
    logic inhibit_force_off;
    logic inhibit_trip;
    logic fault_level;
    logic [31:0] next_rdata;
    rpoc_pkg::rpoc_port_mode_t port_mode;
    rpoc_pkg::rpoc_trig_src_t trig_src;
    rpoc_pkg::rpoc_inhibit_mode_t inhibit_mode;
    rpoc_pkg::rpoc_fault_src_t fault_src;

    rpoc_pin_if pin1();

    rpoc_pin_cond #(
        .MIN_PULSE_CYCLES(TRIG_MIN_CYCLES)
    ) u_pin_cond (
        .clk(clk),
        .reset_n(reset_n),
        .pin(inhibit_input_pin),
        .port(pin1.cond)
    );

    // true for a write strobe to one register
    function automatic logic wr_hit(input logic we, input logic [7:0] a, input logic [7:0] t);
        wr_hit = we && (a == t);
    endfunction

    // decoded control fields; a single mode field keeps functions exclusive
    assign port_mode = rpoc_pkg::rpoc_port_mode_t'(ctrl[rpoc_pkg::CTRL_MODE_LSB +: 2]);
    assign trig_src = rpoc_pkg::rpoc_trig_src_t'(ctrl[rpoc_pkg::CTRL_TSRC_LSB +: 2]);
    assign inhibit_mode = rpoc_pkg::rpoc_inhibit_mode_t'(ctrl[rpoc_pkg::CTRL_INHIBIT_LSB +: 2]);
    assign fault_src = rpoc_pkg::rpoc_fault_src_t'(ctrl[rpoc_pkg::CTRL_FSRC_LSB +: 3]);

    // command strobes
    assign bus_trig = wr_hit(reg_write, reg_addr, rpoc_pkg::ADDR_CMD)
        && reg_wdata[rpoc_pkg::CMD_BUS_TRIG_BIT];
    assign clr_latch = wr_hit(reg_write, reg_addr, rpoc_pkg::ADDR_CMD)
        && reg_wdata[rpoc_pkg::CMD_CLR_LATCH_BIT];
    // turning the output on rearms timer and clears a latched inhibit
    assign out_req_set = wr_hit(reg_write, reg_addr, rpoc_pkg::ADDR_CTRL)
        && reg_wdata[rpoc_pkg::CTRL_OUT_REQ_BIT] && !ctrl[rpoc_pkg::CTRL_OUT_REQ_BIT];

    // control register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= rpoc_pkg::CTRL_RESET;
        end else if (wr_hit(reg_write, reg_addr, rpoc_pkg::ADDR_CTRL)) begin
            ctrl <= reg_wdata[10:0];
        end
    end

    // timer preset in seconds
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_load <= rpoc_pkg::TIMER_LOAD_RESET;
        end else if (wr_hit(reg_write, reg_addr, rpoc_pkg::ADDR_TIMER_LOAD)) begin
            timer_load <= reg_wdata[rpoc_pkg::TIMER_W-1:0];
        end
    end

    // digital output value, only reaches the pin in digital I/O function
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dio_out <= 1'b0;
        end else if (wr_hit(reg_write, reg_addr, rpoc_pkg::ADDR_DIO)) begin
            dio_out <= reg_wdata[0];
        end
    end

    // trigger source select; other sources are ignored entirely
    always_comb begin
        next_trigger = 1'b0;
        case (trig_src)
            rpoc_pkg::RPOC_TSRC_KEY: begin
                next_trigger = trigger_key;
            end
            rpoc_pkg::RPOC_TSRC_EXTERNAL: begin
                // pin one is only a trigger in trigger function
                next_trigger = pin1.trig && (port_mode == rpoc_pkg::RPOC_PORT_TRIGGER);
            end
            rpoc_pkg::RPOC_TSRC_BUS: begin
                next_trigger = bus_trig;
            end
            default: begin
                next_trigger = 1'b0;
            end
        endcase
    end

    // registered; one cycle wide for bus and pin sources, as wide as the key press for the key source
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trigger_pulse <= 1'b0;
        end else begin
            trigger_pulse <= next_trigger;
        end
    end

    // latching inhibit: set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latched_off <= 1'b0;
        end else if (port_mode == rpoc_pkg::RPOC_PORT_INHIBIT_FAULT
                && inhibit_mode == rpoc_pkg::RPOC_INHIBIT_LATCHING && pin1.fall) begin
            latched_off <= 1'b1;
        end else if (clr_latch || out_req_set
                || inhibit_mode != rpoc_pkg::RPOC_INHIBIT_LATCHING) begin
            latched_off <= 1'b0;
        end
    end

    // inhibit decision per mode
    always_comb begin
        inhibit_force_off = 1'b0;
        if (port_mode == rpoc_pkg::RPOC_PORT_INHIBIT_FAULT) begin
            case (inhibit_mode)
                rpoc_pkg::RPOC_INHIBIT_LATCHING: begin
                    inhibit_force_off = latched_off;
                end
                rpoc_pkg::RPOC_INHIBIT_LIVE: begin
                    inhibit_force_off = !pin1.level;
                end
                default: begin
                    inhibit_force_off = 1'b0;
                end
            endcase
        end
    end

    // one-second prescaler, runs only while the timer counts
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sec_count <= 32'h0000_0000;
        end else if (!timer_run || out_req_set) begin
            sec_count <= 32'h0000_0000;
        end else if (sec_count >= 32'(SECOND_CYCLES - 1)) begin
            sec_count <= 32'h0000_0000;
        end else begin
            sec_count <= sec_count + 32'h0000_0001;
        end
    end

    assign timer_run = ctrl[rpoc_pkg::CTRL_TIMER_EN_BIT] && output_on && !timer_expired;

    // output timer countdown; reloaded whenever output is requested on
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_left <= rpoc_pkg::TIMER_LOAD_RESET;
            timer_expired <= 1'b0;
        end else if (out_req_set || !ctrl[rpoc_pkg::CTRL_TIMER_EN_BIT]) begin
            timer_left <= timer_load;
            timer_expired <= 1'b0;
        end else if (timer_run && timer_left == rpoc_pkg::TIMER_LOAD_RESET) begin
            timer_expired <= 1'b1;
        end else if (timer_run && sec_count >= 32'(SECOND_CYCLES - 1)) begin
            timer_left <= timer_left - 16'h0001;
        end
    end

    // output enable: request gated by inhibit and expired timer
    assign output_on = ctrl[rpoc_pkg::CTRL_OUT_REQ_BIT] && !inhibit_force_off
        && !timer_expired;

    // fault level is the chosen status bit inverted, high when off
    always_comb begin
        fault_level = 1'b1;
        case (fault_src)
            rpoc_pkg::RPOC_FSRC_QUES: begin
                fault_level = !status_bits[0];
            end
            rpoc_pkg::RPOC_FSRC_OPER: begin
                fault_level = !status_bits[1];
            end
            rpoc_pkg::RPOC_FSRC_ESB: begin
                fault_level = !status_bits[2];
            end
            rpoc_pkg::RPOC_FSRC_RQS: begin
                fault_level = !status_bits[3];
            end
            default: begin
                fault_level = 1'b1;
            end
        endcase
    end

    // second pin: fault in inhibit function, data in I/O, undriven for trigger
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_output_pin <= 1'b1;
            fault_output_pin_oe <= 1'b0;
        end else begin
            case (port_mode)
                rpoc_pkg::RPOC_PORT_INHIBIT_FAULT: begin
                    fault_output_pin <= fault_level;
                    fault_output_pin_oe <= 1'b1;
                end
                rpoc_pkg::RPOC_PORT_DIO: begin
                    fault_output_pin <= dio_out;
                    fault_output_pin_oe <= 1'b1;
                end
                default: begin
                    fault_output_pin <= 1'b1;
                    fault_output_pin_oe <= 1'b0;
                end
            endcase
        end
    end

    // interrupt events: trigger, inhibit switch-off, timer expiry
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_prev <= 1'b0;
        end else begin
            out_prev <= timer_expired;
        end
    end

    // falling inhibit edge that takes a requested output off; the edge itself
    // is used because latched_off only follows it one cycle later
    assign inhibit_trip = port_mode == rpoc_pkg::RPOC_PORT_INHIBIT_FAULT && pin1.fall
        && ctrl[rpoc_pkg::CTRL_OUT_REQ_BIT]
        && (inhibit_mode == rpoc_pkg::RPOC_INHIBIT_LATCHING
        || inhibit_mode == rpoc_pkg::RPOC_INHIBIT_LIVE);

    assign irq_event[rpoc_pkg::IRQ_TRIG_BIT] = next_trigger;
    assign irq_event[rpoc_pkg::IRQ_INHIBIT_BIT] = inhibit_trip;
    assign irq_event[rpoc_pkg::IRQ_TIMER_BIT] = timer_expired && !out_prev;

    // sticky status, write one to clear, a new event wins over the clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= 3'h0;
        end else if (wr_hit(reg_write, reg_addr, rpoc_pkg::ADDR_IRQ_STATUS)) begin
            irq_status <= (irq_status & ~reg_wdata[rpoc_pkg::IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask <= 3'h0;
        end else if (wr_hit(reg_write, reg_addr, rpoc_pkg::ADDR_IRQ_MASK)) begin
            irq_mask <= reg_wdata[rpoc_pkg::IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (reg_addr)
            rpoc_pkg::ADDR_CTRL: begin
                next_rdata = {21'h000000, ctrl};
            end
            rpoc_pkg::ADDR_TIMER_LOAD: begin
                next_rdata = {16'h0000, timer_load};
            end
            rpoc_pkg::ADDR_DIO: begin
                next_rdata = {30'h00000000, dio_out, pin1.level};
            end
            rpoc_pkg::ADDR_STATUS: begin
                next_rdata = {28'h0000000, pin1.level, timer_expired, latched_off, output_on};
            end
            rpoc_pkg::ADDR_TIMER_LEFT: begin
                next_rdata = {16'h0000, timer_left};
            end
            rpoc_pkg::ADDR_IRQ_STATUS: begin
                next_rdata = {29'h00000000, irq_status};
            end
            rpoc_pkg::ADDR_IRQ_MASK: begin
                next_rdata = {29'h00000000, irq_mask};
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // read data stand only in the cycle after the read strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule

//--- src/rpoc_pkg.sv
package rpoc_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TIMER_LOAD = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_DIO = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_TIMER_LEFT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;

    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TSRC_LSB = 2;
    localparam int CTRL_INHIBIT_LSB = 4;
    localparam int CTRL_FSRC_LSB = 6;
    localparam int CTRL_TIMER_EN_BIT = 9;
    localparam int CTRL_OUT_REQ_BIT = 10;
    localparam logic [10:0] CTRL_RESET = 11'h000;

    // command register bits (write only, self clearing)
    localparam int CMD_BUS_TRIG_BIT = 0;
    localparam int CMD_CLR_LATCH_BIT = 1;

    // status register bits
    localparam int STAT_OUT_ON_BIT = 0;
    localparam int STAT_LATCHED_BIT = 1;
    localparam int STAT_EXPIRED_BIT = 2;
    localparam int STAT_PIN_BIT = 3;

    // interrupt bits
    localparam int IRQ_TRIG_BIT = 0;
    localparam int IRQ_INHIBIT_BIT = 1;
    localparam int IRQ_TIMER_BIT = 2;
    localparam int IRQ_W = 3;

    localparam int TIMER_W = 16;
    localparam logic [TIMER_W-1:0] TIMER_LOAD_RESET = 16'h0000;

    // timing
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    localparam int TRIG_MIN_MS = 5;
    localparam int TRIG_MIN_CYCLES = (TRIG_MIN_MS * 1_000_000 + CLK_NS - 1) / CLK_NS;
    localparam int SECOND_CYCLES = CLK_HZ;

    typedef enum logic [1:0] {
        RPOC_PORT_TRIGGER,
        RPOC_PORT_INHIBIT_FAULT,
        RPOC_PORT_DIO,
        RPOC_PORT_SPARE
    } rpoc_port_mode_t;

    typedef enum logic [1:0] {
        RPOC_TSRC_KEY,
        RPOC_TSRC_EXTERNAL,
        RPOC_TSRC_BUS,
        RPOC_TSRC_NONE
    } rpoc_trig_src_t;

    typedef enum logic [1:0] {
        RPOC_INHIBIT_OFF,
        RPOC_INHIBIT_LATCHING,
        RPOC_INHIBIT_LIVE,
        RPOC_INHIBIT_SPARE
    } rpoc_inhibit_mode_t;

    typedef enum logic [2:0] {
        RPOC_FSRC_OFF,
        RPOC_FSRC_QUES,
        RPOC_FSRC_OPER,
        RPOC_FSRC_ESB,
        RPOC_FSRC_RQS
    } rpoc_fault_src_t;
endpackage

//--- src/rpoc_pin_if.sv
`timescale 1ns/1ps
// conditioned view of the first port pin
interface rpoc_pin_if;
    logic level;
    logic fall;
    logic trig;

    modport cond (output level, output fall, output trig);
    modport user (input level, input fall, input trig);
endinterface

//--- src/rpoc_pin_cond.sv
`timescale 1ns/1ps
module rpoc_pin_cond #(
    parameter int MIN_PULSE_CYCLES = rpoc_pkg::TRIG_MIN_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pin,
    rpoc_pin_if.cond port
);
    logic meta;
    logic sync;
    logic prev;
    logic [31:0] high_count;
    logic fired;

    // two-stage synchroniser, meta read only by sync
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= 1'b1;
            sync <= 1'b1;
            prev <= 1'b1;
        end else begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    // qualify trigger pulses: high for the least width, one event per pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            high_count <= 32'h0000_0000;
            fired <= 1'b0;
        end else if (!sync) begin
            high_count <= 32'h0000_0000;
            fired <= 1'b0;
        end else if (!fired) begin
            if (high_count >= 32'(MIN_PULSE_CYCLES - 1)) begin
                fired <= 1'b1;
            end else begin
                high_count <= high_count + 32'h0000_0001;
            end
        end
    end

    assign port.level = sync;
    assign port.fall = prev & ~sync;
    assign port.trig = sync & ~fired & (high_count >= 32'(MIN_PULSE_CYCLES - 1));
endmodule

//--- tb/rpoc_top_monitor.sv
`timescale 1ns/1ps
// port-level checks on the rear port block
module rpoc_top_monitor #(
    parameter int TRIG_MIN_CYCLES = 10,
    parameter int SECOND_CYCLES = 20
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic inhibit_input_pin,
    input wire logic fault_output_pin,
    input wire logic fault_output_pin_oe,
    input wire logic trigger_key,
    input wire logic [3:0] status_bits,
    input wire logic trigger_pulse,
    input wire logic output_on,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // a read answer only ever follows a read strobe
    sequence s_no_read;
        !reg_read;
    endsequence
    sequence s_pin_seen;
        $past(inhibit_input_pin, 2);
    endsequence

    a_rdata_idle: assert property (s_no_read |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    a_idle_high: assert property (!fault_output_pin_oe |-> fault_output_pin)
        else $error("undriven fault pin not high");
    a_oe_by_write: assert property ($changed(fault_output_pin_oe) |->
        $past(reg_write) || $past(reg_write, 2))
        else $error("pin drive changed without a mode write");
    a_fault_follows: assert property ($changed(fault_output_pin) |->
        $past(reg_write) || $past(reg_write, 2) || $past(status_bits) != $past(status_bits, 2))
        else $error("fault pin moved without a cause");
    a_trig_cause: assert property (trigger_pulse |->
        $past(trigger_key) || $past(reg_write) || $past(inhibit_input_pin, 3))
        else $error("trigger pulse without a source event");
    a_trig_single: assert property (trigger_pulse && !trigger_key && !reg_write |=>
        !trigger_pulse)
        else $error("trigger pulse longer than one cycle");
    a_output_rise: assert property ($rose(output_on) |-> $past(reg_write) or s_pin_seen)
        else $error("output switched on without request or pin");
    a_irq_cause: assert property ($rose(irq) |->
        trigger_pulse || !output_on || $past(reg_write))
        else $error("interrupt rose without an event");
endmodule

bind rpoc_top rpoc_top_monitor #(
    .TRIG_MIN_CYCLES(TRIG_MIN_CYCLES),
    .SECOND_CYCLES(SECOND_CYCLES)
) u_mon (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .inhibit_input_pin(inhibit_input_pin), .fault_output_pin(fault_output_pin),
    .fault_output_pin_oe(fault_output_pin_oe), .trigger_key(trigger_key),
    .status_bits(status_bits), .trigger_pulse(trigger_pulse), .output_on(output_on),
    .irq(irq)
);

//--- tb/rpoc_ttl_model.sv
`timescale 1ns/1ps
// external ttl equipment on port pin one
module rpoc_ttl_model (
    input wire logic clk,
    input wire logic level,
    input wire logic go,
    input wire logic [7:0] len,
    output logic pin
);
    int left = 0;
    // a pulse overrides the idle level; short pulses only when asked for
    always @(posedge clk) begin
        if (go) begin
            left <= int'(len);
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
    assign pin = (left > 0) ? 1'b1 : level;
endmodule

//--- tb/rpoc_top_tb.sv
`timescale 1ns/1ps
module rpoc_top_tb;
    localparam int TMIN = 10;
    localparam int SEC = 20;
    logic clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, trigger_key = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v, rnd = 32'h984c;
    logic [3:0] status_bits = 4'h0;
    logic fault_output_pin, fault_output_pin_oe, trigger_pulse, output_on, irq, pin;
    logic level = 1'b0, go = 1'b0;
    logic [7:0] len = 8'h00;
    int n_mismatch = 0, checks = 0, npulse = 0, n0;

    rpoc_top #(.TRIG_MIN_CYCLES(TMIN), .SECOND_CYCLES(SEC)) dut (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .inhibit_input_pin(pin), .fault_output_pin(fault_output_pin),
        .fault_output_pin_oe(fault_output_pin_oe), .trigger_key(trigger_key),
        .status_bits(status_bits), .trigger_pulse(trigger_pulse), .output_on(output_on),
        .irq(irq)
    );
    rpoc_ttl_model u_ttl (.clk(clk), .level(level), .go(go), .len(len), .pin(pin));

    initial begin
        forever #5 clk = ~clk;
    end
    // count trigger events seen on the port
    always @(posedge clk) begin
        if (trigger_pulse === 1'b1) npulse++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(what, exp, v);
    endtask
    task automatic pulse(input logic [7:0] n);
        @(posedge clk);
        len <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (n + 20) @(posedge clk);
    endtask
    task automatic wait_chk(input int n, input string what, input logic exp, input logic got);
        repeat (n) @(posedge clk);
        #1 chk(what, {31'h0, exp}, {31'h0, output_on});
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test;
    end

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rdc("ctrl", rpoc_pkg::ADDR_CTRL, 32'h0);
        rdc("tload", rpoc_pkg::ADDR_TIMER_LOAD, 32'h0);
        rdc("irqst", rpoc_pkg::ADDR_IRQ_STATUS, 32'h0);
        rdc("unmapped", 8'h20, 32'h0);
        // every source against every stimulus, plus a too-short pin pulse
        for (int s = 0; s < 4; s++) begin
            wr(rpoc_pkg::ADDR_CTRL, 32'(s << 2));
            n0 = npulse;
            @(posedge clk) trigger_key <= 1'b1;
            @(posedge clk) trigger_key <= 1'b0;
            wr(rpoc_pkg::ADDR_CMD, 32'h1);
            pulse(8'(TMIN + 2));
            pulse(8'(TMIN / 2));
            chk("pulses", (s < 3) ? 32'h1 : 32'h0, 32'(npulse - n0));
            chk("oe_trig", 32'h0, {31'h0, fault_output_pin_oe});
        end
        wr(rpoc_pkg::ADDR_IRQ_MASK, 32'h7);
        #1 chk("irq_set", 32'h1, {31'h0, irq});
        wr(rpoc_pkg::ADDR_IRQ_STATUS, 32'h1);
        #1 chk("irq_clr", 32'h0, {31'h0, irq});
        // inhibit modes: latching, live, off
        level <= 1'b1;
        wr(rpoc_pkg::ADDR_CTRL, 32'h0);
        wr(rpoc_pkg::ADDR_CTRL, 32'h411);
        wait_chk(4, "latch_on", 1'b1, output_on);
        level <= 1'b0;
        wait_chk(6, "latch_off", 1'b0, output_on);
        level <= 1'b1;
        wait_chk(6, "latch_hold", 1'b0, output_on);
        rdc("status", rpoc_pkg::ADDR_STATUS, 32'ha);
        rdc("irq_inhibit", rpoc_pkg::ADDR_IRQ_STATUS, 32'h2);
        wr(rpoc_pkg::ADDR_CMD, 32'h2);
        wait_chk(2, "latch_clr", 1'b1, output_on);
        wr(rpoc_pkg::ADDR_CTRL, 32'h421);
        wait_chk(2, "live_hi", 1'b1, output_on);
        level <= 1'b0;
        wait_chk(6, "live_lo", 1'b0, output_on);
        level <= 1'b1;
        wait_chk(6, "live_hi2", 1'b1, output_on);
        wr(rpoc_pkg::ADDR_CTRL, 32'h401);
        level <= 1'b0;
        wait_chk(6, "inhibit_off", 1'b1, output_on);
        // fault pin sources with random status levels
        for (int f = 0; f < 5; f++) begin
            rnd = lfsr(rnd);
            status_bits <= rnd[3:0];
            wr(rpoc_pkg::ADDR_CTRL, 32'(1 | (f << 6)));
            repeat (3) @(posedge clk);
            #1 chk("fault", (f == 0) ? 32'h1 : {31'h0, ~rnd[f - 1]}, {31'h0, fault_output_pin});
            chk("oe_inhibit", 32'h1, {31'h0, fault_output_pin_oe});
        end
        // digital input and output
        wr(rpoc_pkg::ADDR_CTRL, 32'h2);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            level <= rnd[1];
            wr(rpoc_pkg::ADDR_DIO, {31'h0, rnd[0]});
            repeat (4) @(posedge clk);
            #1 chk("dio_out", {31'h0, rnd[0]}, {31'h0, fault_output_pin});
            rdc("dio_in", rpoc_pkg::ADDR_DIO, {30'h0, rnd[0], rnd[1]});
        end
        // output timer of two seconds
        level <= 1'b0;
        wr(rpoc_pkg::ADDR_CTRL, 32'h0);
        wr(rpoc_pkg::ADDR_IRQ_STATUS, 32'h7);
        wr(rpoc_pkg::ADDR_TIMER_LOAD, 32'h2);
        wr(rpoc_pkg::ADDR_CTRL, 32'h600);
        wait_chk(2 * SEC - 10, "tmr_run", 1'b1, output_on);
        wait_chk(20, "tmr_done", 1'b0, output_on);
        rdc("tmr_stat", rpoc_pkg::ADDR_STATUS, 32'h4);
        rdc("tmr_irq", rpoc_pkg::ADDR_IRQ_STATUS, 32'h4);
        finish_test;
    end
endmodule
